// *** verilog/az_pkg.sv ***
// Shared constants, types and decode functions of the alphabetic zone store
`default_nettype none
package az_pkg;

    // ==========================================================
    // Geometry
    localparam int AZ_COLS = 8;

    // ==========================================================
    // APB register map (byte addresses)
    localparam logic [7:0] AZ_OFF_CTRL = 8'h00;
    localparam logic [7:0] AZ_OFF_STATUS = 8'h04;
    localparam logic [7:0] AZ_OFF_ZONE_FIRST = 8'h08;
    localparam logic [7:0] AZ_OFF_ZONE_SECOND = 8'h0C;

    // Control fields and reset value
    localparam int AZ_CTRL_RI_SEL = 0;
    localparam int AZ_CTRL_RO_EN = 1;
    localparam logic [1:0] AZ_CTRL_RESET = 2'h0;

    // Status fields
    localparam int AZ_ST_READ_IN = 0;
    localparam int AZ_ST_READOUT = 1;
    localparam int AZ_ST_XFER_FIRST = 2;
    localparam int AZ_ST_XFER_SECOND = 3;
    localparam int AZ_ST_NUMERIC = 4;
    localparam int AZ_ST_COUNTER_RI = 5;

    // ==========================================================
    // Punch emitter spot now under the punch
    typedef enum logic [1:0] {
        AZ_SPOT_NONE = 2'b00,
        AZ_SPOT_12 = 2'b01,
        AZ_SPOT_11 = 2'b10,
        AZ_SPOT_0 = 2'b11
    } az_spot_type;

    // Readout sequence
    typedef enum logic [1:0] {
        AZ_RO_IDLE = 2'b00,
        AZ_RO_ZONE = 2'b01,
        AZ_RO_NUMERIC = 2'b10
    } az_ro_state_type;

    // ==========================================================
    // Stored pair matches the spot: 12 = first, 0 = second, 11 = both
    function automatic logic az_zone_match(input logic first, input logic second, input az_spot_type spot);
        logic hit;
        hit = 1'b0;
        unique case (spot)
            AZ_SPOT_12: hit = first && !second;
            AZ_SPOT_11: hit = first && second;
            AZ_SPOT_0: hit = !first && second;
            AZ_SPOT_NONE: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // Word address is one of the four registers
    function automatic logic az_is_mapped(input logic [7:0] addr);
        return (addr == AZ_OFF_CTRL) || (addr == AZ_OFF_STATUS) ||
               (addr == AZ_OFF_ZONE_FIRST) || (addr == AZ_OFF_ZONE_SECOND);
    endfunction

endpackage
`default_nettype wire

// *** verilog/az_zone_cell.sv ***
// One column position: the two zone storage elements and its punch decode
`default_nettype none
module az_zone_cell
    import az_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clear,
    input wire logic cap_en,
    input wire logic xfer_first,
    input wire logic xfer_second,
    input wire logic zone_12,
    input wire logic zone_11,
    input wire logic zone_0,
    input wire logic punch_gate,
    input wire az_spot_type spot,
    output logic first_q,
    output logic second_q,
    output logic magnet
);

    // ==========================================================
    // State
    typedef struct packed {
        logic first;
        logic second;
    } az_cell_state_type;

    az_cell_state_type s_q;
    az_cell_state_type s_d;

    // Capture only ever sets; a new group read-in is the sole clear
    always_comb
    begin
        s_d = s_q;
        if (clear)
        begin
            s_d = '0;
        end
        else if (cap_en)
        begin
            if (zone_12 && xfer_second)
            begin
                s_d.first = 1'b1;
            end
            if (zone_0 && xfer_first)
            begin
                s_d.second = 1'b1;
            end
            if (zone_11 && xfer_first && xfer_second)
            begin
                s_d.first = 1'b1;
                s_d.second = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Magnet only through the held transfer path
    assign first_q = s_q.first;
    assign second_q = s_q.second;
    assign magnet = punch_gate && az_zone_match(s_q.first, s_q.second, spot);

endmodule
`default_nettype wire

// *** verilog/az_readout_ctl.sv ***
// Zone readout switch and readout sequencing toward the summary punch
`default_nettype none
module az_readout_ctl
    import az_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic punch_transfer_relay,
    input wire logic punch_end_relay,
    input wire logic punch_zone_time_cam,
    input wire logic ro_enable,
    output logic readout_sw,
    output logic ro_hold,
    output logic numeric_phase
);

    // ==========================================================
    // State
    typedef struct packed {
        az_ro_state_type st;
        logic seen;
    } az_ro_ctl_type;

    az_ro_ctl_type s_q;
    az_ro_ctl_type s_d;

    // Sequence: latch on transfer, zones while cam closed, then numerics
    always_comb
    begin
        s_d = s_q;
        unique case (s_q.st)
            AZ_RO_IDLE:
            begin
                s_d.seen = 1'b0;
            end
            AZ_RO_ZONE:
            begin
                if (punch_zone_time_cam && ro_enable)
                begin
                    s_d.seen = 1'b1;
                end
                if (s_q.seen && !punch_zone_time_cam)
                begin
                    s_d.st = AZ_RO_NUMERIC;
                end
            end
            AZ_RO_NUMERIC:
            begin
                s_d.seen = s_q.seen;
            end
            default:
            begin
                s_d.st = AZ_RO_IDLE;
                s_d.seen = 1'b0;
            end
        endcase
        // Set wins over release so a back-to-back punch is not lost
        if (punch_transfer_relay)
        begin
            s_d.st = AZ_RO_ZONE;
            s_d.seen = 1'b0;
        end
        else if (punch_end_relay)
        begin
            s_d.st = AZ_RO_IDLE;
            s_d.seen = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q <= '{st: AZ_RO_IDLE, seen: 1'b0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Hold only through the punch cam; its opening drops it at once
    assign readout_sw = (s_q.st != AZ_RO_IDLE);
    assign ro_hold = (s_q.st == AZ_RO_ZONE) && ro_enable && punch_zone_time_cam;
    assign numeric_phase = (s_q.st == AZ_RO_NUMERIC);

endmodule
`default_nettype wire

// *** verilog/az_zone_store.sv ***
// Top of the alphabetic zone store: read-in control, transfer elements, APB
//
// The implementer's own choices: the register offsets and register access over APB.
`default_nettype none
module az_zone_store
    import az_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic first_card_minor,
    input wire logic read_in_pick_cam,
    input wire logic read_in_hold_cam,
    input wire logic zone_xfer_cam_first,
    input wire logic zone_xfer_cam_second,
    input wire logic [AZ_COLS-1:0] entry_zone_12,
    input wire logic [AZ_COLS-1:0] entry_zone_11,
    input wire logic [AZ_COLS-1:0] entry_zone_0,
    input wire logic punch_transfer_relay,
    input wire logic punch_end_relay,
    input wire logic punch_zone_time_cam,
    input wire az_spot_type emitter_spot,
    output logic [AZ_COLS-1:0] punch_magnet,
    output logic counter_read_in,
    output logic zone_readout_active,
    output logic numeric_punch_enable
);

    // ==========================================================
    // State of the top
    typedef struct packed {
        logic [1:0] ctrl;
        logic read_in_control_switch;
        logic zone_transfer_first;
        logic zone_transfer_second;
        logic [AZ_COLS-1:0] magnet;
        logic counter_ri;
        logic readout;
        logic numeric;
        logic [31:0] rdata;
        logic ready;
        logic err;
    } az_top_state_type;

    az_top_state_type s_q;
    az_top_state_type s_d;

    // ==========================================================
    // Readout sequencing
    logic readout_sw;
    logic ro_hold;
    logic numeric_phase;

    az_readout_ctl u_readout (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .punch_transfer_relay(punch_transfer_relay),
        .punch_end_relay(punch_end_relay),
        .punch_zone_time_cam(punch_zone_time_cam),
        .ro_enable(s_q.ctrl[AZ_CTRL_RO_EN]),
        .readout_sw(readout_sw),
        .ro_hold(ro_hold),
        .numeric_phase(numeric_phase)
    );

    // ==========================================================
    // Zone storage, one pair per column
    logic ri_pick;
    logic ri_start;
    logic cap_en;
    logic punch_gate;
    logic [AZ_COLS-1:0] zone_first;
    logic [AZ_COLS-1:0] zone_second;
    logic [AZ_COLS-1:0] magnet_raw;

    // Pick only on the first card of a new minor group, when selected
    assign ri_pick = first_card_minor && s_q.ctrl[AZ_CTRL_RI_SEL] && read_in_pick_cam;
    // Fresh read-in wipes the previous group's zones
    assign ri_start = ri_pick && !s_q.read_in_control_switch;
    // Capture runs alongside the numeric add, never during readout
    assign cap_en = s_q.read_in_control_switch && !readout_sw;
    // Punch path needs the readout switch, both held transfer elements and the read-in switch off
    assign punch_gate = readout_sw && s_q.zone_transfer_first && s_q.zone_transfer_second &&
                        !s_q.read_in_control_switch;

    genvar gi;
    generate
        for (gi = 0; gi < AZ_COLS; gi++)
        begin : g_col
            az_zone_cell u_cell (
                .clk_sys(clk_sys),
                .resetn(resetn),
                .clear(ri_start),
                .cap_en(cap_en),
                .xfer_first(s_q.zone_transfer_first),
                .xfer_second(s_q.zone_transfer_second),
                .zone_12(entry_zone_12[gi]),
                .zone_11(entry_zone_11[gi]),
                .zone_0(entry_zone_0[gi]),
                .punch_gate(punch_gate),
                .spot(emitter_spot),
                .first_q(zone_first[gi]),
                .second_q(zone_second[gi]),
                .magnet(magnet_raw[gi])
            );
        end
    endgenerate

    // ==========================================================
    // APB decode helpers
    logic setup;
    logic done;
    logic [31:0] rd_val;
    logic [31:0] status_word;

    assign setup = psel && !penable && !s_q.ready;
    assign done = psel && penable && s_q.ready;

    // Status shows live switch and element state
    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[AZ_ST_READ_IN] = s_q.read_in_control_switch;
        status_word[AZ_ST_READOUT] = s_q.readout;
        status_word[AZ_ST_XFER_FIRST] = s_q.zone_transfer_first;
        status_word[AZ_ST_XFER_SECOND] = s_q.zone_transfer_second;
        status_word[AZ_ST_NUMERIC] = s_q.numeric;
        status_word[AZ_ST_COUNTER_RI] = s_q.counter_ri;
    end

    // Read mux; narrow fields sit low, the rest reads zero
    always_comb
    begin
        rd_val = 32'h0000_0000;
        unique case (paddr)
            AZ_OFF_CTRL: rd_val = {30'h0000_0000, s_q.ctrl};
            AZ_OFF_STATUS: rd_val = status_word;
            AZ_OFF_ZONE_FIRST: rd_val = {24'h00_0000, zone_first};
            AZ_OFF_ZONE_SECOND: rd_val = {24'h00_0000, zone_second};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // ==========================================================
    // Next-state logic
    always_comb
    begin
        s_d = s_q;

        // Read-in switch: picked, then held only while the hold cam dwells
        s_d.read_in_control_switch = ri_pick ||
                                     (s_q.read_in_control_switch && read_in_hold_cam);

        // Transfer elements: unheld pulses at read-in, cam hold at readout
        s_d.zone_transfer_first = (s_q.read_in_control_switch && zone_xfer_cam_first) ||
                                  ro_hold;
        s_d.zone_transfer_second = (s_q.read_in_control_switch && zone_xfer_cam_second) ||
                                   ro_hold;

        // Counter takes numerics on the same read-in cycle
        s_d.counter_ri = s_q.read_in_control_switch;

        // Punch magnets and phase flags, registered for clean outputs
        s_d.magnet = magnet_raw;
        s_d.readout = readout_sw;
        // Numerics only once both transfers have fallen away
        s_d.numeric = numeric_phase && !ro_hold &&
                      !s_q.zone_transfer_first && !s_q.zone_transfer_second;

        // APB: answer in the first access cycle, one wait-free beat
        if (setup)
        begin
            s_d.ready = 1'b1;
            s_d.err = !az_is_mapped(paddr);
            s_d.rdata = pwrite ? 32'h0000_0000 : rd_val;
        end
        else if (done)
        begin
            s_d.ready = 1'b0;
            s_d.err = 1'b0;
            // Only the control register is writable
            if (pwrite && (paddr == AZ_OFF_CTRL))
            begin
                s_d.ctrl = pwdata[1:0];
            end
        end
        else
        begin
            s_d.ready = 1'b0;
            s_d.err = 1'b0;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q <= '0;
            s_q.ctrl <= AZ_CTRL_RESET;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs, all straight from the state register
    assign prdata = s_q.rdata;
    assign pready = s_q.ready;
    assign pslverr = s_q.err;
    assign punch_magnet = s_q.magnet;
    assign counter_read_in = s_q.counter_ri;
    assign zone_readout_active = s_q.readout;
    assign numeric_punch_enable = s_q.numeric;

endmodule
`default_nettype wire

// *** tb/az_zone_store_chk.sv ***
// Port-level assertions for the alphabetic zone store
`default_nettype none
module az_zone_store_chk
    import az_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic first_card_minor,
    input wire logic read_in_pick_cam,
    input wire logic read_in_hold_cam,
    input wire logic punch_transfer_relay,
    input wire logic punch_end_relay,
    input wire logic punch_zone_time_cam,
    input wire az_spot_type emitter_spot,
    input wire logic [AZ_COLS-1:0] punch_magnet,
    input wire logic counter_read_in,
    input wire logic zone_readout_active,
    input wire logic numeric_punch_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // ========================================
    // Register bus answer: one wait-free cycle
    chk_apb_ready_next: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    chk_apb_ready_once: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_apb_err_map: assert property (pready |-> pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h0C))
        else $error("pslverr does not match address");

    // ========================================
    // Read-in switch: picked on a first card, kept by the hold cam
    chk_read_in_pick: assert property ($rose(counter_read_in) |-> $past(read_in_pick_cam, 2))
        else $error("read-in switch set without pick");
    chk_read_in_hold: assert property (counter_read_in && $past(read_in_hold_cam) |=> counter_read_in)
        else $error("read-in switch dropped under hold cam");

    // ========================================
    // Readout switch and zone punching
    chk_readout_latch: assert property ($rose(zone_readout_active) |-> $past(punch_transfer_relay, 2))
        else $error("readout switch set without transfer");
    chk_readout_release: assert property ($past(punch_end_relay, 2) && !$past(punch_transfer_relay, 2)
        |-> !zone_readout_active)
        else $error("readout switch kept after punch end");
    chk_magnet_cam: assert property (punch_magnet != '0 |-> $past(punch_zone_time_cam, 2))
        else $error("magnet without zone-time cam");
    chk_magnet_spot: assert property (punch_magnet != '0 |-> $past(emitter_spot) != AZ_SPOT_NONE)
        else $error("magnet outside an emitter spot");
    chk_numeric_clear: assert property (numeric_punch_enable |-> punch_magnet == '0)
        else $error("zone magnet during numeric punching");
    chk_numeric_after: assert property ($rose(numeric_punch_enable) |-> !$past(punch_zone_time_cam, 2))
        else $error("numeric phase before cam opened");

    // Main scenarios reached
    cov_read_in: cover property ($rose(counter_read_in));
    cov_magnet: cover property (punch_magnet != '0);
    cov_numeric: cover property ($rose(numeric_punch_enable));
    cov_slverr: cover property (pready && pslverr);
endmodule
`default_nettype wire

// *** tb/az_punch_model.sv ***
// Summary punch model: transfer relay, zone-time cam, emitter spots, end relay
`default_nettype none
module az_punch_model
    import az_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic start,
    input wire logic [3:0] gap,
    input wire logic [AZ_COLS-1:0] punch_magnet,
    output logic punch_transfer_relay,
    output logic punch_end_relay,
    output logic punch_zone_time_cam,
    output az_spot_type emitter_spot,
    output logic [AZ_COLS-1:0] got_12,
    output logic [AZ_COLS-1:0] got_11,
    output logic [AZ_COLS-1:0] got_0,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] step_q;
    logic [4:0] rel;
    logic late;

    // ========================================
    // Cycle position after the slow-start gap
    assign rel = step_q - 5'(gap) - 5'h02;
    assign late = step_q > 5'(gap) + 5'h01;
    assign busy = step_q != 5'h00;
    assign punch_transfer_relay = step_q == 5'h01;
    assign punch_zone_time_cam = late && rel < 5'h04;
    assign punch_end_relay = late && rel == 5'h08;

    // Emitter walks 12, 11, 0 while the cam is closed
    always_comb
    begin
        emitter_spot = AZ_SPOT_NONE;
        if (punch_zone_time_cam && rel == 5'h01)
            emitter_spot = AZ_SPOT_12;
        if (punch_zone_time_cam && rel == 5'h02)
            emitter_spot = AZ_SPOT_11;
        if (punch_zone_time_cam && rel == 5'h03)
            emitter_spot = AZ_SPOT_0;
    end

    // Sequence and punched-hole capture; magnets lag the spot by one cycle
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            step_q <= 5'h00;
            got_12 <= '0;
            got_11 <= '0;
            got_0 <= '0;
        end
        else if (start && !busy)
        begin
            step_q <= 5'h01;
            got_12 <= '0;
            got_11 <= '0;
            got_0 <= '0;
        end
        else if (busy)
        begin
            step_q <= punch_end_relay ? 5'h00 : step_q + 5'h01;
            if (late && rel == 5'h02)
                got_12 <= got_12 | punch_magnet;
            if (late && rel == 5'h03)
                got_11 <= got_11 | punch_magnet;
            if (late && rel == 5'h04)
                got_0 <= got_0 | punch_magnet;
        end
    end
endmodule
`default_nettype wire

// *** tb/az_zone_store_tb.sv ***
// Self-checking bench for the alphabetic zone store
`default_nettype none
module az_zone_store_tb
    import az_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, start, busy;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic first_card_minor, read_in_pick_cam, read_in_hold_cam, zone_xfer_cam_first, zone_xfer_cam_second;
    logic [AZ_COLS-1:0] entry_zone_12, entry_zone_11, entry_zone_0, punch_magnet, got_12, got_11, got_0;
    logic punch_transfer_relay, punch_end_relay, punch_zone_time_cam, e, nseen;
    logic counter_read_in, zone_readout_active, numeric_punch_enable;
    az_spot_type emitter_spot;
    logic [3:0] gap;
    logic [15:0] z, zs;
    logic [1:0] ctl;
    int seed, mismatches, total_checks;

    az_zone_store uut (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .first_card_minor, .read_in_pick_cam, .read_in_hold_cam, .zone_xfer_cam_first,
        .zone_xfer_cam_second, .entry_zone_12, .entry_zone_11, .entry_zone_0, .punch_transfer_relay,
        .punch_end_relay, .punch_zone_time_cam, .emitter_spot, .punch_magnet, .counter_read_in,
        .zone_readout_active, .numeric_punch_enable);
    az_punch_model punch (.clk_sys, .resetn, .start, .gap, .punch_magnet, .punch_transfer_relay,
        .punch_end_relay, .punch_zone_time_cam, .emitter_spot, .got_12, .got_11, .got_0, .busy);

    // ========================================
    // Clock and watchdog
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        close_out();
    end

    // Columns whose stored code equals c (1 = 12, 2 = 11, 3 = zero)
    function automatic logic [AZ_COLS-1:0] sel(input logic [15:0] v, input logic [1:0] c);
        for (int i = 0; i < AZ_COLS; i++)
            sel[i] = v[2*i+:2] == c;
    endfunction

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        if (mismatches == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // One APB transfer; answer taken at the ready edge, then one idle edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1)
            @(posedge clk_sys);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    // First card of a group: pick, hold, transfer cams, then zone impulses
    task automatic read_in(input logic [15:0] v);
        first_card_minor <= 1'b1;
        read_in_pick_cam <= 1'b1;
        @(posedge clk_sys);
        first_card_minor <= 1'b0;
        read_in_pick_cam <= 1'b0;
        {read_in_hold_cam, zone_xfer_cam_first, zone_xfer_cam_second} <= 3'h7;
        @(posedge clk_sys);
        entry_zone_12 <= sel(v, 2'h1);
        entry_zone_11 <= sel(v, 2'h2);
        entry_zone_0 <= sel(v, 2'h3);
        @(posedge clk_sys);
        cmp(32'(counter_read_in), 32'(ctl[0]));
        {read_in_hold_cam, zone_xfer_cam_first, zone_xfer_cam_second} <= 3'h0;
        {entry_zone_12, entry_zone_11, entry_zone_0} <= '0;
        repeat (3) @(posedge clk_sys);
    endtask

    // ========================================
    // Main sequence
    initial
    begin
        seed = 32'h149DA7CA;
        {resetn, psel, penable, pwrite, paddr, pwdata, start, gap} = '0;
        {first_card_minor, read_in_pick_cam, read_in_hold_cam, zone_xfer_cam_first, zone_xfer_cam_second} = '0;
        {entry_zone_12, entry_zone_11, entry_zone_0} = '0;
        zs = '0;
        repeat (10) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        apb(1'b0, AZ_OFF_CTRL, 32'h0);
        cmp(r, 32'(AZ_CTRL_RESET));
        apb(1'b1, 8'h10, 32'hFFFFFFFF);
        cmp(32'(e), 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        cmp({r[30:0], e}, 32'h1);
        apb(1'b1, AZ_OFF_STATUS, 32'hFFFFFFFF);
        apb(1'b0, AZ_OFF_STATUS, 32'h0);
        cmp({r[30:0], e}, 32'h0);
        for (int k = 0; k < 8; k++)
        begin
            z = (k == 0) ? 16'hE4E4 : 16'($random(seed));
            ctl = (k == 2) ? 2'h2 : ((k == 4) ? 2'h1 : 2'h3);
            gap <= 4'(k * 2);
            apb(1'b1, AZ_OFF_CTRL, {30'h0, ctl});
            apb(1'b0, AZ_OFF_CTRL, 32'h0);
            cmp(r, {30'h0, ctl});
            read_in(z);
            if (ctl[0])
                zs = z;
            start <= 1'b1;
            @(posedge clk_sys);
            start <= 1'b0;
            nseen = 1'b0;
            @(negedge clk_sys);
            // Numeric phase shows up before the punch ends only when readout is enabled
            while (busy)
            begin
                nseen = nseen | numeric_punch_enable;
                @(negedge clk_sys);
            end
            cmp(32'(nseen), 32'(ctl[1]));
            cmp(32'(got_12), ctl[1] ? 32'(sel(zs, 2'h1)) : 32'h0);
            cmp(32'(got_11), ctl[1] ? 32'(sel(zs, 2'h2)) : 32'h0);
            cmp(32'(got_0), ctl[1] ? 32'(sel(zs, 2'h3)) : 32'h0);
            repeat (3) @(posedge clk_sys);
            cmp(32'(zone_readout_active), 32'h0);
            apb(1'b0, AZ_OFF_ZONE_FIRST, 32'h0);
            cmp(r, 32'(sel(zs, 2'h1) | sel(zs, 2'h2)));
            apb(1'b0, AZ_OFF_ZONE_SECOND, 32'h0);
            cmp(r, 32'(sel(zs, 2'h2) | sel(zs, 2'h3)));
        end
        close_out();
    end
endmodule

bind az_zone_store az_zone_store_chk chk_u (.clk_sys, .resetn, .psel, .penable, .paddr, .pready, .pslverr,
    .first_card_minor, .read_in_pick_cam, .read_in_hold_cam, .punch_transfer_relay, .punch_end_relay,
    .punch_zone_time_cam, .emitter_spot, .punch_magnet, .counter_read_in, .zone_readout_active,
    .numeric_punch_enable);
`default_nettype wire
